// >>> arrival_pkg.sv
package arrival_pkg;

	// frequency words are unsigned, one count per 0.01 Hz
	localparam int FREQ_W = 16;
	localparam int CODE_W = 8;
	localparam int TERM_N = 3;

	// terminal index in the code register and the status word
	localparam int TERM_11 = 0;
	localparam int TERM_12 = 1;
	localparam int TERM_RELAY = 2;

	// function-select codes
	localparam logic [CODE_W-1:0] CODE_RUN = 8'h00;
	localparam logic [CODE_W-1:0] CODE_ARRIVAL_CONST = 8'h01;
	localparam logic [CODE_W-1:0] CODE_ARRIVAL_OVER = 8'h02;

	// hysteresis bands as divisors of the maximum frequency: 1 % on, 2 % off
	localparam int ON_BAND_DIV = 100;
	localparam int OFF_BAND_DIV = 50;

	// register byte offsets
	localparam logic [7:0] SET_FREQ_OFS = 8'h00;
	localparam logic [7:0] START_FREQ_OFS = 8'h04;
	localparam logic [7:0] ACCEL_ON_OFS = 8'h08;
	localparam logic [7:0] DECEL_OFF_OFS = 8'h0C;
	localparam logic [7:0] MAX_FREQ_OFS = 8'h10;
	localparam logic [7:0] FUNC_SEL_OFS = 8'h14;
	localparam logic [7:0] STATUS_OFS = 8'h18;

	// values after reset
	localparam logic [FREQ_W-1:0] SET_FREQ_RST = 16'h1770;
	localparam logic [FREQ_W-1:0] START_FREQ_RST = 16'h0032;
	localparam logic [FREQ_W-1:0] ACCEL_ON_RST = 16'h0000;
	localparam logic [FREQ_W-1:0] DECEL_OFF_RST = 16'h0000;
	localparam logic [FREQ_W-1:0] MAX_FREQ_RST = 16'h1770;
	localparam logic [CODE_W-1:0] FUNC_11_RST = 8'h00;
	localparam logic [CODE_W-1:0] FUNC_12_RST = 8'h01;
	localparam logic [CODE_W-1:0] FUNC_RELAY_RST = 8'h02;
	// terminal pins released: both open-collector pins high, relay coil off
	localparam logic [TERM_N-1:0] PIN_LVL_RST = 3'h3;
	localparam logic HREADY_RST = 1'h1;
	localparam logic HRESP_RST = 1'h0;

	// AHB transfer type
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	// AHB transfer size of one whole word
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	typedef struct packed {
		logic run_active;
		logic const_arrival;
		logic over_arrival;
	} detect_state_t;

	typedef struct packed {
		logic [FREQ_W-1:0] set_freq;
		logic [FREQ_W-1:0] start_freq;
		logic [FREQ_W-1:0] accel_on;
		logic [FREQ_W-1:0] decel_off;
		logic [FREQ_W-1:0] max_freq;
		logic [TERM_N-1:0][CODE_W-1:0] func_sel;
		logic [TERM_N-1:0] term_on;
		logic [TERM_N-1:0] pin_lvl;
		logic ready;
		logic resp;
		logic wr_pend;
		logic [7:0] wr_addr;
		logic [31:0] rdata;
	} top_state_t;

endpackage

// >>> arrival_detector.sv
`timescale 1ns/100ps

module arrival_detector
(
	// clock and reset
	input wire logic i_clock,
	input wire logic i_reset_n,
	// drive state
	input wire logic i_run,
	input wire logic [arrival_pkg::FREQ_W-1:0] i_out_freq,
	// programmed parameters
	input wire logic [arrival_pkg::FREQ_W-1:0] i_set_frequency_param,
	input wire logic [arrival_pkg::FREQ_W-1:0] i_start_frequency_param,
	input wire logic [arrival_pkg::FREQ_W-1:0] i_accel_on_threshold_param,
	input wire logic [arrival_pkg::FREQ_W-1:0] i_decel_off_threshold_param,
	input wire logic [arrival_pkg::FREQ_W-1:0] i_max_freq,
	// detected functions
	output logic o_run_active,
	output logic o_arrival_constant_speed,
	output logic o_arrival_over_threshold
);

	arrival_pkg::detect_state_t state_reg;
	arrival_pkg::detect_state_t state_next;
	logic [arrival_pkg::FREQ_W-1:0] on_band;
	logic [arrival_pkg::FREQ_W-1:0] off_band;
	logic [arrival_pkg::FREQ_W-1:0] diff;
	logic [arrival_pkg::FREQ_W:0] freq_plus_on;
	logic [arrival_pkg::FREQ_W:0] freq_plus_off;

	// bands and distances; the extra bit keeps the early-on sum from wrapping
	always_comb
	begin
		on_band = arrival_pkg::FREQ_W'(i_max_freq / arrival_pkg::ON_BAND_DIV);
		off_band = arrival_pkg::FREQ_W'(i_max_freq / arrival_pkg::OFF_BAND_DIV);
		diff = (i_out_freq >= i_set_frequency_param) ? i_out_freq - i_set_frequency_param
			: i_set_frequency_param - i_out_freq;
		freq_plus_on = {1'b0, i_out_freq} + {1'b0, on_band};
		freq_plus_off = {1'b0, i_out_freq} + {1'b0, off_band};
	end

	// next state; a stopped motor clears both arrival flags at once
	always_comb
	begin
		state_next = state_reg;
		state_next.run_active = i_run && (i_out_freq > i_start_frequency_param);
		if (!state_next.run_active)
		begin
			state_next.const_arrival = 1'b0;
			state_next.over_arrival = 1'b0;
		end
		else
		begin
			// turn on inside the narrow band, release only past the wide one
			if (!state_reg.const_arrival)
				state_next.const_arrival = (diff <= on_band);
			else
				state_next.const_arrival = (diff <= off_band);
			// separate on and off thresholds, each shifted by its band
			if (!state_reg.over_arrival)
				state_next.over_arrival =
					(freq_plus_on >= {1'b0, i_accel_on_threshold_param});
			else
				state_next.over_arrival =
					(freq_plus_off >= {1'b0, i_decel_off_threshold_param});
		end
	end

	// state register
	always_ff @(posedge i_clock)
	begin
		if (!i_reset_n)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	assign o_run_active = state_reg.run_active;
	assign o_arrival_constant_speed = state_reg.const_arrival;
	assign o_arrival_over_threshold = state_reg.over_arrival;

endmodule // arrival_detector

// >>> run_and_freq_arrival_outputs.sv
// The register offsets and the AHB-Lite register port were decided locally.
`timescale 1ns/100ps

// Notes on behaviour
// - code 00 asserts the terminal in run mode above the start frequency, releases it otherwise.
// - open-collector terminals 11 and 12 are active low, low meaning transistor on; the relay coil is active high.
// - code 01 asserts at constant target speed, releases when off or ramping.
// - code 02 asserts from one on band below the accel threshold upward, ramps included.
// - code 02 releases when off or once the output falls more than the off band below the decel threshold.
// - over-threshold uses one accel on and another decel off threshold.
// - every arrival transition while running carries hysteresis against chatter; a stop clears both flags at once.
// - functions are assignable to terminals 11, 12 and the relay.
// - constant-speed on within 1 percent of max, off beyond 2 percent.
// - over-threshold compares accel threshold to turn on, decel to turn off.
module run_and_freq_arrival_outputs
(
	// clock and reset
	input wire logic i_clock,
	input wire logic i_reset_n,
	// drive state from the frequency ramp
	input wire logic i_run,
	input wire logic [arrival_pkg::FREQ_W-1:0] i_out_freq,
	// AHB-Lite slave
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	// output terminals
	output logic o_term11_n,
	output logic o_term12_n,
	output logic o_relay_coil
);

	// Timing at a glance, in rising edges of the control clock:
	// - a write is taken at its address-phase edge and lands at the edge that ends
	//   its data phase; a read whose address phase overlaps that data phase already
	//   returns the new word, because the fetch looks at the next-state copy
	// - a read fetches its word at the address-phase edge, shows it for the one
	//   data-phase cycle and then lets the read data lines fall back to zero
	// - a change of run or frequency reaches the detector flags one edge later and
	//   the terminal pins one edge after that
	// - a new function code reaches the pins one edge after it lands
	// Run and frequency come from the ramp logic on this same clock, so they are not
	// synchronised; a source on another clock would need two flops in front and two
	// more edges of latency everywhere above.

	// Register map, one word each, unused upper bits read as zero:
	// - set frequency: the constant-speed target
	// - start frequency: run status needs the output strictly above it
	// - accel on threshold: over-threshold turn-on level
	// - decel off threshold: over-threshold turn-off level
	// - max frequency: base of both hysteresis bands
	// - function select: byte 0 terminal 11, byte 1 terminal 12, byte 2 relay
	// - status, read only: flags in bits 2:0, terminal states in bits 6:4

	// state, detector flags, terminal selection and bus decode
	arrival_pkg::top_state_t state_reg;
	arrival_pkg::top_state_t state_next;
	logic run_active;
	logic arrival_constant_speed;
	logic arrival_over_threshold;
	logic [arrival_pkg::TERM_N-1:0] term_sel;
	logic addr_phase;
	logic [7:0] rd_addr;
	logic [31:0] status_word;
	logic in_page;
	logic word_size;
	logic wr_req;
	logic rd_req;
	logic [arrival_pkg::TERM_N-1:0] pin_next;

	// comparison and hysteresis state lives in the detector
	// it sees the parameters straight from their flops, so a word written in a
	// data phase is compared from the following edge on; the cost is one edge of
	// latency against keeping the detector free of any bus timing
	arrival_detector detector
	(
		.i_clock(i_clock),
		.i_reset_n(i_reset_n),
		.i_run(i_run),
		.i_out_freq(i_out_freq),
		.i_set_frequency_param(state_reg.set_freq),
		.i_start_frequency_param(state_reg.start_freq),
		.i_accel_on_threshold_param(state_reg.accel_on),
		.i_decel_off_threshold_param(state_reg.decel_off),
		.i_max_freq(state_reg.max_freq),
		.o_run_active(run_active),
		.o_arrival_constant_speed(arrival_constant_speed),
		.o_arrival_over_threshold(arrival_over_threshold)
	);

	// one selector per terminal; unknown codes leave the terminal released
	// the selector reads the registered codes, so a new code needs one edge to act,
	// and the pin flop behind it keeps any decode glitch off the terminal
	genvar t;
	generate
		for (t = 0; t < arrival_pkg::TERM_N; t++)
		begin : g_term
			always_comb
			begin
				unique case (state_reg.func_sel[t])
					arrival_pkg::CODE_RUN: term_sel[t] = run_active;
					arrival_pkg::CODE_ARRIVAL_CONST: term_sel[t] = arrival_constant_speed;
					arrival_pkg::CODE_ARRIVAL_OVER: term_sel[t] = arrival_over_threshold;
					default: term_sel[t] = 1'b0;
				endcase
				// released level: open-collector pin high, relay coil off
				if (t == arrival_pkg::TERM_RELAY)
					pin_next[t] = term_sel[t];
				else
					pin_next[t] = !term_sel[t];
			end
		end
	endgenerate

	// bus decode and the live status word
	always_comb
	begin
		// an address phase counts only once the previous transfer has finished
		addr_phase = i_hsel && i_hready && i_htrans[1];
		// only the lowest 256 bytes decode; the rest of the slot reads zero
		in_page = (i_haddr[31:8] == 24'h000000);
		// registers hold whole words; a narrower write is dropped, never merged
		word_size = (i_hsize == arrival_pkg::HSIZE_WORD);
		wr_req = addr_phase && i_hwrite && in_page && word_size;
		rd_req = addr_phase && !i_hwrite && in_page;
		rd_addr = i_haddr[7:0];
		status_word = '0;
		status_word[0] = run_active;
		status_word[1] = arrival_constant_speed;
		status_word[2] = arrival_over_threshold;
		status_word[6:4] = state_reg.term_on;
	end

	// registers, bus pipeline and terminal flops in one next-state process
	// the write commit comes before the read fetch so that a read overlapping a
	// write's data phase returns the word just written, not the stale one
	always_comb
	begin
		state_next = state_reg;
		state_next.term_on = term_sel;
		state_next.pin_lvl = pin_next;
		// every register answers at once: no wait states, always OKAY
		state_next.ready = 1'h1;
		state_next.resp = 1'h0;
		// data phase of a write: commit i_hwdata to the address captured last cycle
		if (state_reg.wr_pend)
		begin
			unique case (state_reg.wr_addr)
				arrival_pkg::SET_FREQ_OFS: state_next.set_freq = i_hwdata[15:0];
				arrival_pkg::START_FREQ_OFS: state_next.start_freq = i_hwdata[15:0];
				arrival_pkg::ACCEL_ON_OFS: state_next.accel_on = i_hwdata[15:0];
				arrival_pkg::DECEL_OFF_OFS: state_next.decel_off = i_hwdata[15:0];
				arrival_pkg::MAX_FREQ_OFS: state_next.max_freq = i_hwdata[15:0];
				arrival_pkg::FUNC_SEL_OFS: state_next.func_sel = i_hwdata[23:0];
				default: ;
			endcase
		end
		// address phase: note writes, fetch read data so it stands in the data phase
		// out-of-page and unmapped reads leave the data at zero
		state_next.wr_pend = wr_req;
		state_next.wr_addr = rd_addr;
		state_next.rdata = '0;
		if (rd_req)
		begin
			unique case (rd_addr)
				arrival_pkg::SET_FREQ_OFS: state_next.rdata = {16'h0000, state_next.set_freq};
				arrival_pkg::START_FREQ_OFS: state_next.rdata = {16'h0000, state_next.start_freq};
				arrival_pkg::ACCEL_ON_OFS: state_next.rdata = {16'h0000, state_next.accel_on};
				arrival_pkg::DECEL_OFF_OFS: state_next.rdata = {16'h0000, state_next.decel_off};
				arrival_pkg::MAX_FREQ_OFS: state_next.rdata = {16'h0000, state_next.max_freq};
				arrival_pkg::FUNC_SEL_OFS: state_next.rdata = {8'h00, state_next.func_sel};
				arrival_pkg::STATUS_OFS: state_next.rdata = status_word;
				default: state_next.rdata = '0;
			endcase
		end
	end

	// state register; synchronous reset to the power-up defaults
	// the bus pipeline flops reset too, so a transfer cut short by reset never lands
	always_ff @(posedge i_clock)
	begin
		if (!i_reset_n)
		begin
			state_reg.set_freq <= arrival_pkg::SET_FREQ_RST;
			state_reg.start_freq <= arrival_pkg::START_FREQ_RST;
			state_reg.accel_on <= arrival_pkg::ACCEL_ON_RST;
			state_reg.decel_off <= arrival_pkg::DECEL_OFF_RST;
			state_reg.max_freq <= arrival_pkg::MAX_FREQ_RST;
			state_reg.func_sel <= {arrival_pkg::FUNC_RELAY_RST, arrival_pkg::FUNC_12_RST,
				arrival_pkg::FUNC_11_RST};
			state_reg.term_on <= '0;
			state_reg.pin_lvl <= arrival_pkg::PIN_LVL_RST;
			state_reg.ready <= arrival_pkg::HREADY_RST;
			state_reg.resp <= arrival_pkg::HRESP_RST;
			state_reg.wr_pend <= 1'b0;
			state_reg.wr_addr <= '0;
			state_reg.rdata <= '0;
		end
		else
			state_reg <= state_next;
	end

	// bus answers straight from their flops
	assign o_hreadyout = state_reg.ready;
	assign o_hresp = state_reg.resp;
	assign o_hrdata = state_reg.rdata;
	// pin levels are flops of their own, so no gate sits between a flop and a pin;
	// open-collector terminals pull low when asserted, the relay coil energises
	assign o_term11_n = state_reg.pin_lvl[arrival_pkg::TERM_11];
	assign o_term12_n = state_reg.pin_lvl[arrival_pkg::TERM_12];
	assign o_relay_coil = state_reg.pin_lvl[arrival_pkg::TERM_RELAY];

endmodule // run_and_freq_arrival_outputs

// >>> status_sensor.sv
`timescale 1ns/100ps
module status_sensor
(
	// pins from the drive
	input wire logic i_term11_n,
	input wire logic i_term12_n,
	input wire logic i_relay_coil,
	// on/off as the equipment sees it: t11, t12, relay
	output logic [2:0] o_seen
);
	// pulled-up inputs read on only when the transistor sinks; contact closes with the coil
	assign o_seen = {i_term11_n === 1'b0, i_term12_n === 1'b0, i_relay_coil === 1'b1};
endmodule // status_sensor

// >>> arrival_props.sv
`timescale 1ns/100ps
module arrival_props
(
	// clock and reset
	input wire logic i_clock,
	input wire logic i_reset_n,
	// drive state and bus
	input wire logic i_run,
	input wire logic [arrival_pkg::FREQ_W-1:0] i_out_freq,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic i_hready,
	// block answers
	input wire logic [31:0] o_hrdata,
	input wire logic o_hreadyout,
	input wire logic o_hresp,
	input wire logic o_term11_n,
	input wire logic o_term12_n,
	input wire logic o_relay_coil
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_reset_n);
	// read address phase, and every terminal released
	wire logic rd = i_hsel && i_hready && i_htrans[1] && !i_hwrite;
	wire logic rel = o_term11_n && o_term12_n && !o_relay_coil;
	property p_ready; o_hreadyout; endproperty
	a_ready: assert property (p_ready) else $error("wait state seen");
	property p_okay; !o_hresp; endproperty
	a_okay: assert property (p_okay) else $error("error response seen");
	property p_idle; !rd |=> o_hrdata == 32'h0; endproperty
	a_idle: assert property (p_idle) else $error("read data without read");
	property p_unmap; rd && i_haddr > 32'h1B |=> o_hrdata == 32'h0; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_upper; rd && i_haddr < 32'h14 |=> o_hrdata[31:16] == 16'h0; endproperty
	a_upper: assert property (p_upper) else $error("parameter upper bits set");
	// arrival flags need a running motor; run flag needs run two edges back
	property p_stat;
		rd && i_haddr == 32'h18 |=> o_hrdata[31:7] == 25'h0
			&& (o_hrdata[2:1] == 2'h0 || o_hrdata[0]) && (!o_hrdata[0] || $past(i_run, 2));
	endproperty
	a_stat: assert property (p_stat) else $error("status word wrong");
	property p_off; !i_run |-> ##2 rel; endproperty
	a_off: assert property (p_off) else $error("terminal on in stop");
	property p_zero; i_out_freq == 16'h0 |-> ##2 rel; endproperty
	a_zero: assert property (p_zero) else $error("terminal on at zero");
	cover property (rd && i_haddr == 32'h18 ##1 o_hrdata[0]);
	cover property (!o_term11_n);
	cover property (o_relay_coil);
endmodule // arrival_props
bind run_and_freq_arrival_outputs arrival_props props_u (.i_clock, .i_reset_n, .i_run,
	.i_out_freq, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hready, .o_hrdata,
	.o_hreadyout, .o_hresp, .o_term11_n, .o_term12_n, .o_relay_coil);

// >>> testbench.sv
`timescale 1ns/100ps
module testbench;
	logic i_clock = 1'b0;
	logic i_reset_n = 1'b0;
	logic i_run = 1'b0;
	logic [15:0] i_out_freq = 16'h0000;
	logic i_hsel = 1'b0;
	logic i_hwrite = 1'b0;
	logic [1:0] i_htrans = 2'h0;
	logic [2:0] i_hsize = 3'h0, sz = arrival_pkg::HSIZE_WORD;
	logic [31:0] i_haddr = 32'h0, i_hwdata = 32'h0, o_hrdata, q;
	logic o_hreadyout, o_hresp, o_term11_n, o_term12_n, o_relay_coil;
	logic [2:0] seen;
	int fails = 0, n_tests = 0;
	// control clock
	always #20 i_clock = ~i_clock;
	run_and_freq_arrival_outputs dut_u (.i_clock, .i_reset_n, .i_run, .i_out_freq,
		.i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize, .i_hwdata,
		.i_hready(o_hreadyout), .o_hrdata, .o_hreadyout, .o_hresp, .o_term11_n,
		.o_term12_n, .o_relay_coil);
	status_sensor eq_u (.i_term11_n(o_term11_n), .i_term12_n(o_term12_n),
		.i_relay_coil(o_relay_coil), .o_seen(seen));
	task automatic end_sim();
		$display("tests %0d fails %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			fails++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic chk_pins(input logic [2:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			fails++;
			$display("[ERR] %0t pins %b want %b", $time, seen, exp);
		end
	endtask
	// wait for hready at a rising edge; what is read here is what that edge sampled
	task automatic rdy();
		int w;
		for (w = 0; w < 50; w++)
		begin
			@(posedge i_clock);
			if (o_hreadyout === 1'b1)
				break;
		end
		q = o_hrdata;
		if (w == 50)
		begin
			fails++;
			end_sim();
		end
	endtask
	task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
		i_hsel <= 1'b1;
		i_haddr <= a;
		i_hwrite <= wr;
		i_hsize <= sz;
		i_htrans <= arrival_pkg::HTRANS_NONSEQ;
		rdy();
		i_htrans <= 2'h0;
		i_hwdata <= d;
		rdy();
	endtask
	// reset values, read-only status, unmapped hole
	task automatic t_regs();
		logic [31:0] e [7] = '{32'h1770, 32'h32, 32'h0, 32'h0, 32'h1770, 32'h20100, 32'h0};
		for (int i = 0; i < 7; i++)
		begin
			xfer(1'b0, 32'(4 * i), 32'h0);
			chk(q, e[i]);
		end
		xfer(1'b1, 32'h18, 32'hFF);
		xfer(1'b0, 32'h18, 32'h0);
		chk(q, 32'h0);
		xfer(1'b0, 32'h1C, 32'h0);
		chk(q, 32'h0);
		// a byte-sized write must not touch a word register
		sz = 3'h0;
		xfer(1'b1, 32'h0, 32'h1234);
		sz = arrival_pkg::HSIZE_WORD;
		xfer(1'b0, 32'h0, 32'h0);
		chk(q, 32'h1770);
	endtask
	// set 3000, on 1000, off 800, max 6000: bands 60 and 120 counts
	task automatic t_table();
		logic [15:0] f [14] = '{16'h32, 16'h33, 16'h33, 16'h3AB, 16'h3AC, 16'h2BC, 16'h2A7,
			16'h3AB, 16'hB7B, 16'hB7C, 16'hC30, 16'hC31, 16'hBF4, 16'hBF4};
		logic [2:0] e [14] = '{3'h0, 3'h4, 3'h0, 3'h4, 3'h5, 3'h5, 3'h4, 3'h4, 3'h5, 3'h7,
			3'h7, 3'h5, 3'h7, 3'h0};
		xfer(1'b1, 32'h0, 32'hBB8);
		xfer(1'b1, 32'h8, 32'h3E8);
		xfer(1'b1, 32'hC, 32'h320);
		xfer(1'b0, 32'h8, 32'h0);
		chk(q, 32'h3E8);
		for (int i = 0; i < 14; i++)
		begin
			i_run <= (i != 2 && i != 13);
			i_out_freq <= f[i];
			repeat (3) @(posedge i_clock);
			chk_pins(e[i]);
		end
	endtask
	// reassign functions at 2000 counts, including an unused code
	task automatic t_mux();
		i_run <= 1'b1;
		i_out_freq <= 16'h7D0;
		repeat (3) @(posedge i_clock);
		chk_pins(3'h5);
		xfer(1'b1, 32'h14, 32'hFF0201);
		repeat (2) @(posedge i_clock);
		chk_pins(3'h2);
		xfer(1'b0, 32'h18, 32'h0);
		chk(q, 32'h25);
		xfer(1'b1, 32'h14, 32'h0);
		repeat (2) @(posedge i_clock);
		chk_pins(3'h7);
	endtask
	initial
	begin
		repeat (8) @(posedge i_clock);
		i_reset_n <= 1'b1;
		@(posedge i_clock);
		t_regs();
		t_table();
		t_mux();
		end_sim();
	end
endmodule // testbench
